//--- hdl/pbc_regs.sv
// AXI4-Lite register block of the power budget capability
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ns
`include "pbc_defs.svh"
module pbc_regs (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [`PBC_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [`PBC_DATA_W-1:0] s_axi_wdata,
  input wire logic [`PBC_STRB_W-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`PBC_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [`PBC_DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  function automatic pbc_pkg::pbc_target_type decodeAddr(input logic [`PBC_ADDR_W-1:0] addr);
    pbc_pkg::pbc_target_type t;
    t = pbc_pkg::T_NONE;
    if (addr == `PBC_HDR_OFS) t = pbc_pkg::T_HDR;
    else if (addr == `PBC_SEL_OFS) t = pbc_pkg::T_SEL;
    else if (addr == `PBC_OUT_OFS) t = pbc_pkg::T_OUT;
    else if (addr == `PBC_CTL_OFS) t = pbc_pkg::T_CTL;
    else if (addr >= `PBC_ENTRY_FIRST && addr <= `PBC_ENTRY_LAST && addr[1:0] == 2'b00) t = pbc_pkg::T_ENTRY;
    return t;
  endfunction

  function automatic logic [`PBC_DATA_W-1:0] mergeStrb(input logic [`PBC_DATA_W-1:0] old,
                                                       input logic [`PBC_DATA_W-1:0] data,
                                                       input logic [`PBC_STRB_W-1:0] strb);
    logic [`PBC_DATA_W-1:0] res;
    res = old;
    for (int b = 0; b < `PBC_STRB_W; b++) begin
      if (strb[b]) res[8*b +: 8] = data[8*b +: 8];
    end
    return res;
  endfunction

  pbc_pkg::pbc_header_type header;
  logic [`PBC_SEL_W-1:0] budgetEntryIndex;
  logic budgetValueUnlock;

  logic awHeld;
  logic [`PBC_ADDR_W-1:0] awAddr;
  logic wHeld;
  logic [`PBC_DATA_W-1:0] wData;
  logic [`PBC_STRB_W-1:0] wStrb;

  pbc_pkg::pbc_rstate_type rdState;
  pbc_pkg::pbc_target_type rdTarget;
  logic rdSelOut;
  logic [`PBC_DATA_W-1:0] memRdData;

  // Write channel decode
  wire awHs = s_axi_awvalid & s_axi_awready;
  wire wHs = s_axi_wvalid & s_axi_wready;
  wire bHs = s_axi_bvalid & s_axi_bready;
  wire doWrite = ce & awHeld & wHeld & ~s_axi_bvalid;
  wire pbc_pkg::pbc_target_type wrTarget = decodeAddr(awAddr);
  wire hdrWrite = doWrite && wrTarget == pbc_pkg::T_HDR && budgetValueUnlock;
  wire selWrite = doWrite && wrTarget == pbc_pkg::T_SEL;
  wire ctlWrite = doWrite && wrTarget == pbc_pkg::T_CTL;
  wire memWrEn = doWrite && wrTarget == pbc_pkg::T_ENTRY && budgetValueUnlock;
  wire [`PBC_DATA_W-1:0] next_header = mergeStrb(header, wData, wStrb);
  wire [`PBC_DATA_W-1:0] next_sel32 = mergeStrb({24'h00_0000, budgetEntryIndex}, wData, wStrb);
  wire [`PBC_DATA_W-1:0] next_ctl32 = mergeStrb({31'h0000_0000, budgetValueUnlock}, wData, wStrb);
  wire [1:0] next_bresp = (wrTarget == pbc_pkg::T_NONE) ? `PBC_RESP_SLVERR : `PBC_RESP_OKAY;

  // Read channel decode
  wire arHs = s_axi_arvalid & s_axi_arready;
  wire pbc_pkg::pbc_target_type arTarget = decodeAddr(s_axi_araddr);
  wire [`PBC_ENTRY_AW-1:0] memRdAddr = (arTarget == pbc_pkg::T_OUT) ?
    budgetEntryIndex[`PBC_ENTRY_AW-1:0] : s_axi_araddr[`PBC_ENTRY_IDX_LSB +: `PBC_ENTRY_AW];
  wire memRdEn = arHs && (arTarget == pbc_pkg::T_OUT || arTarget == pbc_pkg::T_ENTRY);
  wire [`PBC_DATA_W-1:0] readoutValue = rdSelOut ? 32'h0000_0000 : memRdData;
  wire [`PBC_DATA_W-1:0] readMux =
    (rdTarget == pbc_pkg::T_HDR) ? header :
    (rdTarget == pbc_pkg::T_SEL) ? {24'h00_0000, budgetEntryIndex} :
    (rdTarget == pbc_pkg::T_OUT) ? readoutValue :
    (rdTarget == pbc_pkg::T_CTL) ? {31'h0000_0000, budgetValueUnlock} :
    (rdTarget == pbc_pkg::T_ENTRY) ? memRdData : 32'h0000_0000;
  wire [1:0] next_rresp = (rdTarget == pbc_pkg::T_NONE) ? `PBC_RESP_SLVERR : `PBC_RESP_OKAY;

  pbc_entry_mem u_entries (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .ce(ce),
    .wrEn(memWrEn),
    .wrAddr(awAddr[`PBC_ENTRY_IDX_LSB +: `PBC_ENTRY_AW]),
    .wrStrb(wStrb),
    .wrData(wData),
    .rdEn(memRdEn),
    .rdAddr(memRdAddr),
    .rdData(memRdData)
  );

  // Header, select and unlock registers; readout has no storage, so writes to it vanish
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      header <= `PBC_HDR_RESET;
      budgetEntryIndex <= `PBC_SEL_RESET;
      budgetValueUnlock <= `PBC_UNLOCK_RESET;
    end else begin
      if (hdrWrite) header <= next_header;
      if (selWrite) budgetEntryIndex <= next_sel32[`PBC_SEL_W-1:0];
      if (ctlWrite) budgetValueUnlock <= next_ctl32[`PBC_UNLOCK_BIT];
    end
  end

  // Write address and data are taken in either order, then answered together
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      awHeld <= 1'b0;
      awAddr <= 12'h000;
      wHeld <= 1'b0;
      wData <= 32'h0000_0000;
      wStrb <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PBC_RESP_OKAY;
    end else if (ce) begin
      if (awHs) begin
        awHeld <= 1'b1;
        awAddr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end else if (doWrite) begin
        awHeld <= 1'b0;
      end
      if (wHs) begin
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end else if (doWrite) begin
        wHeld <= 1'b0;
      end
      if (doWrite) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= next_bresp;
      end else if (bHs) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Read: accept, fetch one cycle for the entry store, then present
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdState <= pbc_pkg::RD_IDLE;
      rdTarget <= pbc_pkg::T_NONE;
      rdSelOut <= 1'b0;
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `PBC_RESP_OKAY;
    end else if (ce) begin
      case (rdState)
        pbc_pkg::RD_IDLE: begin
          if (arHs) begin
            rdTarget <= arTarget;
            rdSelOut <= budgetEntryIndex > `PBC_SEL_MAX;
            s_axi_arready <= 1'b0;
            rdState <= pbc_pkg::RD_FETCH;
          end
        end
        pbc_pkg::RD_FETCH: begin
          s_axi_rdata <= readMux;
          s_axi_rresp <= next_rresp;
          s_axi_rvalid <= 1'b1;
          rdState <= pbc_pkg::RD_RESP;
        end
        default: begin
          if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
            rdState <= pbc_pkg::RD_IDLE;
          end
        end
      endcase
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  wire fetchNow = ce && rdState == pbc_pkg::RD_FETCH;

  hdr_type_field_a: assert property (
    fetchNow && rdTarget == pbc_pkg::T_HDR |=>
      s_axi_rdata[`PBC_TYPE_MSB:`PBC_TYPE_LSB] == $past(header.structureTypeCode))
    else $error("Header type code field misplaced");
  hdr_version_field_a: assert property (
    fetchNow && rdTarget == pbc_pkg::T_HDR |=>
      s_axi_rdata[`PBC_VER_MSB:`PBC_VER_LSB] == $past(header.structureVersion))
    else $error("Header version field misplaced");
  sel_write_a: assert property (
    selWrite && wStrb[0] |=> budgetEntryIndex == $past(wData[7:0]))
    else $error("Select write not stored");
  readout_range_a: assert property (
    arHs && arTarget == pbc_pkg::T_OUT && budgetEntryIndex > `PBC_SEL_MAX && ce ##1 ce[*2] |->
      s_axi_rvalid && s_axi_rdata == 32'h0000_0000)
    else $error("Out of range select did not read zero");
  readout_entry_a: assert property (
    fetchNow && rdTarget == pbc_pkg::T_OUT && !rdSelOut |=> s_axi_rdata == $past(memRdData))
    else $error("Readout does not show selected entry");
  locked_entry_a: assert property (
    doWrite && wrTarget == pbc_pkg::T_ENTRY && !budgetValueUnlock |=>
      $stable(u_entries.budgetValueEntry[awAddr[`PBC_ENTRY_IDX_LSB +: `PBC_ENTRY_AW]]))
    else $error("Locked entry was changed by a write");
  sel_upper_zero_a: assert property (
    fetchNow && rdTarget == pbc_pkg::T_SEL |=> s_axi_rdata[31:8] == 24'h00_0000)
    else $error("Select reserved bits not zero");
  readout_ro_a: assert property (
    doWrite && wrTarget == pbc_pkg::T_OUT |=> s_axi_bvalid && s_axi_bresp == `PBC_RESP_OKAY && $stable(header))
    else $error("Readout write had an effect");

  entry_unlocked_c: cover property (memWrEn);
  readout_in_range_c: cover property (fetchNow && rdTarget == pbc_pkg::T_OUT && !rdSelOut);
  readout_out_range_c: cover property (fetchNow && rdTarget == pbc_pkg::T_OUT && rdSelOut);
  entry_locked_c: cover property (doWrite && wrTarget == pbc_pkg::T_ENTRY && !budgetValueUnlock);
endmodule // pbc_regs

//--- hdl/pbc_defs.svh
// Offsets, field positions, reset values and codes of the power budget capability registers
`ifndef PBC_DEFS_SVH
`define PBC_DEFS_SVH

`define PBC_ADDR_W 12
`define PBC_DATA_W 32
`define PBC_STRB_W 4

`define PBC_HDR_OFS 12'h280
`define PBC_SEL_OFS 12'h284
`define PBC_OUT_OFS 12'h288
`define PBC_CTL_OFS 12'h290
`define PBC_ENTRY_FIRST 12'h300
`define PBC_ENTRY_LAST 12'h31c

`define PBC_TYPE_LSB 0
`define PBC_TYPE_MSB 15
`define PBC_VER_LSB 16
`define PBC_VER_MSB 19
`define PBC_LINK_LSB 20
`define PBC_LINK_MSB 31

`define PBC_TYPE_IN_USE 16'h0004
`define PBC_VER_IN_USE 4'h1

`define PBC_HDR_RESET 32'h0000_0000
`define PBC_SEL_RESET 8'h00
`define PBC_UNLOCK_RESET 1'b0
`define PBC_UNLOCK_BIT 0

`define PBC_SEL_W 8
`define PBC_SEL_MAX 8'h07
`define PBC_ENTRY_NUM 8
`define PBC_ENTRY_AW 3
`define PBC_ENTRY_IDX_LSB 2

`define PBC_RESP_OKAY 2'b00
`define PBC_RESP_SLVERR 2'b10

`endif

//--- hdl/pbc_pkg.sv
// Types shared by the power budget capability register block
package pbc_pkg;

  typedef struct packed {
    logic [11:0] chainLinkOffset;
    logic [3:0] structureVersion;
    logic [15:0] structureTypeCode;
  } pbc_header_type;

  typedef enum logic [2:0] {
    T_HDR,
    T_SEL,
    T_OUT,
    T_CTL,
    T_ENTRY,
    T_NONE
  } pbc_target_type;

  typedef enum {
    RD_IDLE,
    RD_FETCH,
    RD_RESP
  } pbc_rstate_type;

endpackage

//--- hdl/pbc_entry_mem.sv
// Eight power budget value entries with byte-lane writes and registered read data
`timescale 1ns/1ns
`include "pbc_defs.svh"
module pbc_entry_mem (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic wrEn,
  input wire logic [`PBC_ENTRY_AW-1:0] wrAddr,
  input wire logic [`PBC_STRB_W-1:0] wrStrb,
  input wire logic [`PBC_DATA_W-1:0] wrData,
  input wire logic rdEn,
  input wire logic [`PBC_ENTRY_AW-1:0] rdAddr,
  output logic [`PBC_DATA_W-1:0] rdData
);
  logic [`PBC_DATA_W-1:0] budgetValueEntry [`PBC_ENTRY_NUM];

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < `PBC_ENTRY_NUM; i++) begin
        budgetValueEntry[i] <= 32'h0000_0000;
      end
    end else if (ce && wrEn) begin
      for (int b = 0; b < `PBC_STRB_W; b++) begin
        if (wrStrb[b]) budgetValueEntry[wrAddr][8*b +: 8] <= wrData[8*b +: 8];
      end
    end
  end

  // Read sees the contents before a write in the same cycle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) rdData <= 32'h0000_0000;
    else if (ce && rdEn) rdData <= budgetValueEntry[rdAddr];
  end
endmodule // pbc_entry_mem

//--- verification/test_pbc_regs.sv
// Self-checking testbench of the power budget capability register block
`timescale 1ns/1ns
`include "pbc_defs.svh"
module test_pbc_regs;
  typedef struct packed {
    logic [11:0] wAddr;
    logic [31:0] wData;
    logic [11:0] rAddr;
    logic [31:0] rExp;
  } pbc_row_type;

  logic sys_clk, rst_n, ce;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdVal;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  int badCount, testsRun;
  pbc_row_type rows [14];

  pbc_regs u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .ce(ce),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

  always #50 sys_clk = ~sys_clk;

  task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
    testsRun++;
    if (got !== exp) begin
      badCount++;
      $display("[FAIL] t=%0t data got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    testsRun++;
    if (got !== exp) begin
      badCount++;
      $display("[FAIL] t=%0t resp got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Address and data are offered together; each is dropped at the edge that takes it
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    logic awDone, wDone;
    awDone = 1'b0;
    wDone = 1'b0;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(awDone && wDone)) begin
      @(posedge sys_clk);
      if (!awDone && s_axi_awready === 1'b1) begin
        awDone = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!wDone && s_axi_wready === 1'b1) begin
        wDone = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge sys_clk); while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [11:0] a);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge sys_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge sys_clk); while (s_axi_rvalid !== 1'b1);
    rdVal = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    axi_rd(a);
    chk_data(rdVal, exp);
    chk_resp(rsp, `PBC_RESP_OKAY);
  endtask

  task automatic closeOut;
    $display("Comparisons %0d, mismatches %0d", testsRun, badCount);
    if (badCount == 0 && testsRun > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    sys_clk = 1'b0;
    rst_n = 1'b0;
    ce = 1'b1;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    badCount = 0;
    testsRun = 0;
    rows = '{
      '{12'h280, 32'h5a51_0004, 12'h280, 32'h5a51_0004}, '{12'h284, 32'hffff_ff05, 12'h284, 32'h0000_0005},
      '{12'h284, 32'h0000_0000, 12'h288, 32'h1111_1111}, '{12'h284, 32'h0000_0001, 12'h288, 32'h2222_2222},
      '{12'h284, 32'h0000_0002, 12'h288, 32'h3333_3333}, '{12'h284, 32'h0000_0003, 12'h288, 32'h4444_4444},
      '{12'h284, 32'h0000_0004, 12'h288, 32'h5555_5555}, '{12'h284, 32'h0000_0005, 12'h288, 32'h6666_6666},
      '{12'h284, 32'h0000_0006, 12'h288, 32'h7777_7777}, '{12'h284, 32'h0000_0007, 12'h288, 32'h8888_8888},
      '{12'h288, 32'hdead_beef, 12'h288, 32'h8888_8888}, '{12'h284, 32'h0000_0008, 12'h288, 32'h0000_0000},
      '{12'h284, 32'h0000_00ff, 12'h288, 32'h0000_0000}, '{12'h284, 32'h0000_0100, 12'h284, 32'h0000_0000}};
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd_chk(`PBC_HDR_OFS, 32'h0000_0000);
    rd_chk(`PBC_SEL_OFS, 32'h0000_0000);
    rd_chk(`PBC_OUT_OFS, 32'h0000_0000);
    axi_wr(12'h300, 32'h1234_5678, 4'hf);
    rd_chk(12'h300, 32'h0000_0000);
    axi_wr(`PBC_CTL_OFS, 32'h0000_0001, 4'hf);
    rd_chk(`PBC_CTL_OFS, 32'h0000_0001);
    for (int i = 0; i < 8; i++) begin
      axi_wr(12'h300 + 12'(4 * i), 32'(32'h1111_1111 * (i + 1)), 4'hf);
    end
    foreach (rows[i]) begin
      axi_wr(rows[i].wAddr, rows[i].wData, 4'hf);
      chk_resp(rsp, `PBC_RESP_OKAY);
      rd_chk(rows[i].rAddr, rows[i].rExp);
    end
    // Byte lane write lands in one lane only, and the readout follows it at once
    axi_wr(12'h300, 32'habcd_ef12, 4'b0010);
    rd_chk(12'h300, 32'h1111_ef11);
    axi_wr(`PBC_SEL_OFS, 32'h0000_0000, 4'hf);
    rd_chk(`PBC_OUT_OFS, 32'h1111_ef11);
    // Locking again must drop entry writes
    axi_wr(`PBC_CTL_OFS, 32'h0000_0000, 4'hf);
    axi_wr(12'h31c, 32'h0000_0000, 4'hf);
    rd_chk(12'h31c, 32'h8888_8888);
    axi_wr(`PBC_HDR_OFS, 32'h0000_0000, 4'hf);
    rd_chk(`PBC_HDR_OFS, 32'h5a51_0004);
    axi_wr(12'h2a0, 32'hffff_ffff, 4'hf);
    chk_resp(rsp, `PBC_RESP_SLVERR);
    axi_rd(12'h2a0);
    chk_resp(rsp, `PBC_RESP_SLVERR);
    chk_data(rdVal, 32'h0000_0000);
    // Clock enable low freezes a read that has just been taken
    axi_wr(`PBC_SEL_OFS, 32'h0000_0003, 4'hf);
    @(posedge sys_clk);
    s_axi_araddr <= `PBC_OUT_OFS;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge sys_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    ce <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk_data({30'h0000_0000, s_axi_arready, s_axi_rvalid}, 32'h0000_0000);
    ce <= 1'b1;
    do @(posedge sys_clk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk_data(s_axi_rdata, 32'h4444_4444);
    chk_resp(s_axi_rresp, `PBC_RESP_OKAY);
    // Second reset in mid-run clears the header again
    rst_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd_chk(`PBC_HDR_OFS, 32'h0000_0000);
    rd_chk(`PBC_SEL_OFS, 32'h0000_0000);
    closeOut();
  end

  // About 60 transfers of under ten cycles each
  initial begin
    repeat (5000) @(posedge sys_clk);
    badCount++;
    closeOut();
  end
endmodule // test_pbc_regs
